// [common/irr_pkg.sv]
// package for the infrared remote-control receive decoder
package irr_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] IRR_OFF_RBUF3 = 8'h00;
  localparam logic [7:0] IRR_OFF_LEADER = 8'h04;
  localparam logic [7:0] IRR_OFF_MODE = 8'h08;
  localparam logic [7:0] IRR_OFF_THR = 8'h0c;
  localparam logic [7:0] IRR_OFF_STATUS = 8'h10;

  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int IRR_POS_LIEN = 31;
  localparam int IRR_POS_EDIEN = 30;
  localparam int IRR_POS_LD = 25;
  localparam int IRR_POS_PHM = 24;
  localparam int IRR_POS_DATH = 8;
  localparam logic [31:0] IRR_RST_LEADER = 32'h0000_0000;
  localparam logic [31:0] IRR_RST_MODE = 32'h0000_ffff;
  localparam logic [31:0] IRR_RST_THR = 32'h0000_0000;
  localparam logic [7:0] IRR_TRIG_OFF = 8'hff;
  localparam int IRR_LEADER_SCALE = 4;

  // ----------------------------------------------------------------
  // timing and sizes
  // ----------------------------------------------------------------
  localparam int IRR_FS_DIV = 8;
  localparam int IRR_BUF_BITS = 72;
  localparam int IRR_CNT_W = 11;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] lcmax;
    logic [7:0] lcmin;
    logic [7:0] llmax;
    logic [7:0] llmin;
  } irr_leader_t;

  typedef struct packed {
    logic leader_irq_en;
    logic falling_edge_irq_en;
    logic with_or_without_leader;
    logic phase_mode_sel;
    logic [7:0] low_limit;
    logic [7:0] cycle_limit;
  } irr_mode_t;

  typedef struct packed {
    logic [6:0] high_thr;
    logic [6:0] low_thr;
  } irr_thr_t;

  typedef enum logic [2:0] {
    IRR_IDLE = 3'b001,
    IRR_HUNT = 3'b010,
    IRR_DATA = 3'b100
  } irr_state_t;

endpackage : irr_pkg

// [design/irr_receiver.sv]
// infrared remote-control receive decoder with ahb-lite register slave
// Notes on behaviour
// - top buffer word shows received bits 71..64 in low byte, upper bits zero.
// - bits shift in msb-first; newest bit always lands in buffer bit zero.
// - lsb-first frames are not reordered; software reverses them.
// - leader cycle upper limit is bits 31..24 times four sample periods.
// - leader cycle lower limit is bits 23..16 times four sample periods.
// - leader low-width upper limit is bits 15..8 times four sample periods.
// - leader low-width lower limit is bits 7..0 times four sample periods.
// - with leader optional, a low pulse below minimum leader low is data.
// - zero max low means high-only leader; zero max cycle means no leader.
// - mode bit 31 gates the leader-detected interrupt.
// - mode bit 30 gates the falling-edge interrupt.
// - mode bit 25 accepts frames with or without leader.
// - mode bit 24 picks cycle decoding or fixed-frequency phase decoding.
// - low longer than bits 15..8 sample periods ends reception; all-ones disables.
// - data cycle over bits 7..0 sample periods ends reception; all-ones disables.
// - mode word resets to low sixteen bits ones, rest zero.
// - cycle above low threshold is one, else zero; phase mode gives 01 or 00.
// - phase mode only: cycle above high threshold gives 10, else 01 or 00 as above.
`timescale 1ns/1ps
module irr_receiver
  import irr_pkg::*;
#(
  parameter int FS_DIV = IRR_FS_DIV
)
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic unit_enable,
  input wire logic rx_on_switch,
  input wire logic ir_in,
  output logic leader_irq,
  output logic edge_irq,
  output logic done_irq
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [IRR_CNT_W-1:0] irr_x4(input logic [7:0] v);
    irr_x4 = IRR_CNT_W'({v, 2'b00});
  endfunction : irr_x4

  function automatic logic [IRR_CNT_W-1:0] irr_sat_inc(input logic [IRR_CNT_W-1:0] v);
    irr_sat_inc = (&v) ? v : v + 1'b1;
  endfunction : irr_sat_inc

  irr_leader_t leader_limits;
  irr_mode_t rx_mode_and_timeouts;
  irr_thr_t bit_thresholds;
  irr_state_t state;
  logic [IRR_BUF_BITS-1:0] received_bits;
  logic [6:0] bit_count;
  localparam int DIV_W = $clog2(FS_DIV + 1);
  logic [DIV_W-1:0] div_cnt;
  logic fs_tick;
  logic ir_prev;
  logic [IRR_CNT_W-1:0] low_cnt;
  logic [IRR_CNT_W-1:0] cyc_cnt;
  logic rx_active;
  logic fall;
  logic leader_ok;
  logic data_start;
  logic bit_one;
  logic [1:0] phase_pat;
  logic low_timeout;
  logic cyc_timeout;

  // ----------------------------------------------------------------
  // sample-rate divider
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      div_cnt <= '0;
      fs_tick <= 1'b0;
    end
    else if (div_cnt == DIV_W'(FS_DIV - 1))
    begin
      div_cnt <= '0;
      fs_tick <= unit_enable;
    end
    else
    begin
      div_cnt <= div_cnt + 1'b1;
      fs_tick <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // pulse measurement
  // ----------------------------------------------------------------
  // rx_on_switch is expected only after the three control words are set
  assign rx_active = unit_enable && rx_on_switch;
  assign fall = fs_tick && ir_prev && !ir_in;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ir_prev <= 1'b1;
      low_cnt <= '0;
      cyc_cnt <= '0;
    end
    else if (fs_tick)
    begin
      ir_prev <= ir_in;
      if (fall)
      begin
        low_cnt <= IRR_CNT_W'(1);
        cyc_cnt <= IRR_CNT_W'(1);
      end
      else
      begin
        cyc_cnt <= irr_sat_inc(cyc_cnt);
        if (!ir_in)
          low_cnt <= irr_sat_inc(low_cnt);
      end
    end
  end

  // ----------------------------------------------------------------
  // classification of the cycle that a falling edge closes
  // ----------------------------------------------------------------
  always_comb
  begin
    leader_ok = (cyc_cnt >= irr_x4(leader_limits.lcmin)) &&
                (cyc_cnt <= irr_x4(leader_limits.lcmax));
    // zero max low width: a leader made of high time only
    if (leader_limits.llmax != 8'h00)
      leader_ok = leader_ok && (low_cnt >= irr_x4(leader_limits.llmin)) &&
                  (low_cnt <= irr_x4(leader_limits.llmax));
    if (leader_limits.lcmax == 8'h00)
      leader_ok = 1'b0;
    data_start = (leader_limits.lcmax == 8'h00) ||
                 (rx_mode_and_timeouts.with_or_without_leader &&
                  (low_cnt < irr_x4(leader_limits.llmin)));
    bit_one = cyc_cnt > IRR_CNT_W'(bit_thresholds.low_thr);
    if (cyc_cnt > IRR_CNT_W'(bit_thresholds.high_thr))
      phase_pat = 2'b10;
    else if (bit_one)
      phase_pat = 2'b01;
    else
      phase_pat = 2'b00;
  end

  assign low_timeout = (rx_mode_and_timeouts.low_limit != IRR_TRIG_OFF) && !ir_in &&
                       (low_cnt > IRR_CNT_W'(rx_mode_and_timeouts.low_limit));
  assign cyc_timeout = (rx_mode_and_timeouts.cycle_limit != IRR_TRIG_OFF) &&
                       (cyc_cnt > IRR_CNT_W'(rx_mode_and_timeouts.cycle_limit));

  // ----------------------------------------------------------------
  // frame sequencer and receive buffer
  // ----------------------------------------------------------------
  // lsb-first protocols come out reversed; no reordering here by design
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state <= IRR_IDLE;
      received_bits <= '0;
      bit_count <= '0;
      leader_irq <= 1'b0;
      done_irq <= 1'b0;
      edge_irq <= 1'b0;
    end
    else
    begin
      leader_irq <= 1'b0;
      done_irq <= 1'b0;
      edge_irq <= rx_active && fall && rx_mode_and_timeouts.falling_edge_irq_en;
      if (!rx_active)
        state <= IRR_IDLE;
      else
      begin
        case (state)
          IRR_IDLE:
          begin
            if (fall)
              state <= IRR_HUNT;
          end
          IRR_HUNT:
          begin
            if (fall && leader_ok)
            begin
              received_bits <= '0;
              bit_count <= '0;
              leader_irq <= rx_mode_and_timeouts.leader_irq_en;
              state <= IRR_DATA;
            end
            else if (fall && data_start)
            begin
              received_bits <= {{(IRR_BUF_BITS-1){1'b0}}, bit_one};
              bit_count <= 7'd1;
              state <= IRR_DATA;
            end
          end
          IRR_DATA:
          begin
            if (fs_tick && (low_timeout || cyc_timeout))
            begin
              done_irq <= 1'b1;
              state <= IRR_IDLE;
            end
            else if (fall)
            begin
              if (rx_mode_and_timeouts.phase_mode_sel)
              begin
                received_bits <= {received_bits[IRR_BUF_BITS-3:0], phase_pat};
                bit_count <= (bit_count >= 7'd70) ? 7'd72 : bit_count + 7'd2;
              end
              else
              begin
                received_bits <= {received_bits[IRR_BUF_BITS-2:0], bit_one};
                bit_count <= (bit_count >= 7'd72) ? 7'd72 : bit_count + 7'd1;
              end
            end
          end
          default:
            state <= IRR_IDLE;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // ahb-lite slave
  // ----------------------------------------------------------------
  // reads take one wait state so hrdata can come from a flop
  logic wr_pend;
  logic rd_pend;
  logic [7:0] dp_addr;
  logic mode_written;
  logic [31:0] rd_word;

  always_comb
  begin
    case (dp_addr)
      IRR_OFF_RBUF3: rd_word = {24'h00_0000, received_bits[71:64]};
      IRR_OFF_LEADER: rd_word = leader_limits;
      IRR_OFF_MODE: rd_word = {rx_mode_and_timeouts.leader_irq_en, rx_mode_and_timeouts.falling_edge_irq_en,
                               4'h0, rx_mode_and_timeouts.with_or_without_leader,
                               rx_mode_and_timeouts.phase_mode_sel, 8'h00,
                               rx_mode_and_timeouts.low_limit, rx_mode_and_timeouts.cycle_limit};
      IRR_OFF_THR: rd_word = {17'h0_0000, bit_thresholds.high_thr, 1'b0, bit_thresholds.low_thr};
      IRR_OFF_STATUS: rd_word = {22'h00_0000, bit_count, state};
      default: rd_word = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend <= 1'b0;
      rd_pend <= 1'b0;
      dp_addr <= 8'h00;
      hreadyout <= 1'b1;
      hrdata <= 32'h0000_0000;
      hresp <= 1'b0;
    end
    else if (rd_pend)
    begin
      rd_pend <= 1'b0;
      hreadyout <= 1'b1;
      hrdata <= rd_word;
    end
    else
    begin
      wr_pend <= hsel && hready && htrans[1] && hwrite;
      if (hsel && hready && htrans[1])
      begin
        dp_addr <= {haddr[7:2], 2'b00};
        rd_pend <= !hwrite;
        hreadyout <= hwrite;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      leader_limits <= IRR_RST_LEADER;
      rx_mode_and_timeouts <= irr_mode_t'({IRR_RST_MODE[31:30], IRR_RST_MODE[25:24], IRR_RST_MODE[15:0]});
      bit_thresholds <= irr_thr_t'({IRR_RST_THR[14:8], IRR_RST_THR[6:0]});
      mode_written <= 1'b0;
    end
    else if (wr_pend)
    begin
      case (dp_addr)
        IRR_OFF_LEADER: leader_limits <= hwdata;
        IRR_OFF_MODE:
        begin
          rx_mode_and_timeouts <= irr_mode_t'({hwdata[IRR_POS_LIEN], hwdata[IRR_POS_EDIEN],
                                               hwdata[IRR_POS_LD], hwdata[IRR_POS_PHM], hwdata[15:0]});
          mode_written <= 1'b1;
        end
        IRR_OFF_THR: bit_thresholds <= irr_thr_t'({hwdata[IRR_POS_DATH+6:IRR_POS_DATH], hwdata[6:0]});
        default: mode_written <= mode_written;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_top_word_read;
    @(posedge hclk) disable iff (!hresetn)
      (rd_pend && dp_addr == IRR_OFF_RBUF3) |=> (hrdata[31:8] == 24'h00_0000) && hreadyout;
  endproperty
  a_top_word_read: assert property (p_top_word_read) else $error("top buffer word upper bits not zero");

  property p_msb_first;
    @(posedge hclk) disable iff (!hresetn)
      (state == IRR_DATA && rx_active && fall && !rx_mode_and_timeouts.phase_mode_sel &&
       !(fs_tick && (low_timeout || cyc_timeout)))
      |=> received_bits == {$past(received_bits[IRR_BUF_BITS-2:0]), $past(bit_one)};
  endproperty
  a_msb_first: assert property (p_msb_first) else $error("newest bit not at buffer bit zero");

  property p_leader_window;
    @(posedge hclk) disable iff (!hresetn)
      $rose(leader_irq) |-> $past(cyc_cnt) >= irr_x4($past(leader_limits.lcmin)) &&
                            $past(cyc_cnt) <= irr_x4($past(leader_limits.lcmax));
  endproperty
  a_leader_window: assert property (p_leader_window) else $error("leader accepted outside cycle limits");

  property p_leader_gate;
    @(posedge hclk) disable iff (!hresetn)
      leader_irq |-> $past(rx_mode_and_timeouts.leader_irq_en) && state == IRR_DATA;
  endproperty
  a_leader_gate: assert property (p_leader_gate) else $error("leader interrupt while gated");

  property p_edge_gate;
    @(posedge hclk) disable iff (!hresetn)
      (rx_active && fall) |=> edge_irq == $past(rx_mode_and_timeouts.falling_edge_irq_en);
  endproperty
  a_edge_gate: assert property (p_edge_gate) else $error("edge interrupt not following its gate");

  property p_low_timeout;
    @(posedge hclk) disable iff (!hresetn)
      (state == IRR_DATA && rx_active && fs_tick && low_timeout) |=> done_irq && state == IRR_IDLE;
  endproperty
  a_low_timeout: assert property (p_low_timeout) else $error("long low did not end reception");

  property p_cycle_timeout;
    @(posedge hclk) disable iff (!hresetn)
      (state == IRR_DATA && rx_active && fs_tick && cyc_timeout) |=> done_irq;
  endproperty
  a_cycle_timeout: assert property (p_cycle_timeout) else $error("long cycle did not end reception");

  property p_mode_reset;
    @(posedge hclk) disable iff (!hresetn)
      !mode_written |-> rx_mode_and_timeouts == irr_mode_t'({4'h0, 16'hffff});
  endproperty
  a_mode_reset: assert property (p_mode_reset) else $error("mode word reset value wrong");

  property p_phase_pattern;
    @(posedge hclk) disable iff (!hresetn)
      (state == IRR_DATA && rx_active && fall && rx_mode_and_timeouts.phase_mode_sel &&
       !(fs_tick && (low_timeout || cyc_timeout)))
      |=> received_bits[1:0] == ($past(cyc_cnt) > IRR_CNT_W'($past(bit_thresholds.high_thr)) ? 2'b10 :
                                 $past(cyc_cnt) > IRR_CNT_W'($past(bit_thresholds.low_thr)) ? 2'b01 : 2'b00);
  endproperty
  a_phase_pattern: assert property (p_phase_pattern) else $error("phase pattern misclassified");

  property p_hold_after_done;
    @(posedge hclk) disable iff (!hresetn)
      (state == IRR_IDLE) |=> $stable(received_bits);
  endproperty
  a_hold_after_done: assert property (p_hold_after_done) else $error("buffer changed while idle");

  c_leader: cover property (@(posedge hclk) disable iff (!hresetn) leader_irq);
  c_done: cover property (@(posedge hclk) disable iff (!hresetn) done_irq && bit_count == 7'd72);
  c_no_leader_start: cover property (@(posedge hclk) disable iff (!hresetn)
    state == IRR_HUNT && fall && !leader_ok && data_start);
  c_phase_long: cover property (@(posedge hclk) disable iff (!hresetn)
    state == IRR_DATA && fall && rx_mode_and_timeouts.phase_mode_sel && phase_pat == 2'b10);

endmodule : irr_receiver

// [dv/irr_ir_source.sv]
// model of the demodulated infrared source feeding the receiver
`timescale 1ns/1ps
module irr_ir_source
#(
  parameter int FS_DIV = 2
)
(
  input wire logic hclk,
  output logic ir_in
);
  // idle level is high between frames
  initial ir_in = 1'b1;

  task automatic hold(input logic lvl, input int ticks);
    ir_in <= lvl;
    repeat (ticks * FS_DIV) @(posedge hclk);
  endtask : hold

  // lead_low 0 sends no leader; each symbol is one fall-to-fall cycle
  task automatic send(input int lead_low, input int lead_high, input logic phm, input logic [71:0] v, input int nsym);
    int c;
    if (lead_low > 0)
    begin
      hold(1'b0, lead_low);
      hold(1'b1, lead_high);
    end
    for (int i = 0; i < nsym; i++)
    begin
      if (phm)
        c = (v[71-2*i -: 2] == 2'b10) ? 22 : (v[71-2*i -: 2] == 2'b01) ? 14 : 6;
      else
        c = v[71-i] ? 14 : 6;
      hold(1'b0, 3);
      hold(1'b1, c - 3);
    end
    // closing fall, then a high long enough to trip the cycle limit
    hold(1'b0, 3);
    hold(1'b1, 120);
  endtask : send
endmodule : irr_ir_source

// [dv/tb_top.sv]
// self-checking bench for the infrared remote-control receiver
`timescale 1ns/1ps
module tb_top;
  import irr_pkg::*;
  localparam int FSD = 2;
  localparam logic [71:0] PAT_CYC = 72'ha6_3c3c_3c3c_3c3c_3c3c;
  localparam logic [71:0] PAT_PHM = 72'h92_9292_9292_9292_9292;
  // lcmax 20, lcmin 10, llmax 8, llmin 4 (units of four ticks)
  localparam logic [31:0] LIM = 32'h140a_0804;
  logic [31:0] lim = LIM;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, unit_enable, rx_on_switch, ir_in;
  logic leader_irq, edge_irq, done_irq;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  int bad_count, tests_run, n_lead, n_edge, n_done;
  int bad_ll[4] = '{40, 8, 24, 24};
  int bad_lh[4] = '{36, 40, 70, 12};

  assign hready = hreadyout;
  always #20 hclk = ~hclk;
  always @(posedge hclk)
  begin
    n_lead += (leader_irq === 1'b1);
    n_edge += (edge_irq === 1'b1);
    n_done += (done_irq === 1'b1);
  end

  irr_receiver #(.FS_DIV(FSD)) u_irr_receiver (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .unit_enable(unit_enable), .rx_on_switch(rx_on_switch), .ir_in(ir_in),
    .leader_irq(leader_irq), .edge_irq(edge_irq), .done_irq(done_irq));
  irr_ir_source #(.FS_DIV(FSD)) u_irr_ir_source (.hclk(hclk), .ir_in(ir_in));

  // ----------------------------------------------------------------
  // bus and compare tasks
  // ----------------------------------------------------------------
  task automatic wrap_up();
    $display("comparisons %0d, mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : wrap_up

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      $display("[FAIL] %0t: got %h expected %h", $time, got, exp);
      bad_count++;
    end
  endtask : chk

  // address phase held until hready, then data phase until hready again
  // hsel stays up between transfers; an idle htrans keeps the slave quiet
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= wr;
    @(posedge hclk);
    while (hready !== 1'b1)
      @(posedge hclk);
    htrans <= 2'b00;
    hwdata <= wd;
    @(posedge hclk);
    while (hready !== 1'b1)
      @(posedge hclk);
    rd = hrdata;
    chk({31'h0, hresp}, 32'h0);
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask : wr

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    bus(1'b0, a, 32'h0, r);
    chk(r, exp);
  endtask : rdchk

  // negative expectation skips the count
  task automatic cnt(input int got, input int exp);
    if (exp >= 0)
      chk(32'(got), 32'(exp));
  endtask : cnt

  // reception held off while the control words are rewritten
  task automatic cfg(input logic [31:0] mode, input logic on);
    rx_on_switch <= 1'b0;
    wr(IRR_OFF_LEADER, lim);
    wr(IRR_OFF_MODE, mode);
    wr(IRR_OFF_THR, 32'h0000_120a);
    rx_on_switch <= on;
  endtask : cfg

  task automatic run(input logic [31:0] mode, input int ll, input int lh, input logic phm, input logic [71:0] v,
    input int nsym, input logic [7:0] top, input int el, input int ee, input int ed, input logic on);
    int l0, e0, d0;
    cfg(mode, on);
    l0 = n_lead;
    e0 = n_edge;
    d0 = n_done;
    u_irr_ir_source.send(ll, lh, phm, v, nsym);
    rdchk(IRR_OFF_RBUF3, {24'h0, top});
    cnt(n_lead - l0, el);
    cnt(n_edge - e0, ee);
    cnt(n_done - d0, ed);
  endtask : run

  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  initial
  begin
    hclk = 1'b0;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0;
    unit_enable = 1'b1;
    rx_on_switch = 1'b0;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rdchk(IRR_OFF_LEADER, 32'h0000_0000);
    rdchk(IRR_OFF_MODE, 32'h0000_ffff);
    rdchk(IRR_OFF_THR, 32'h0000_0000);
    rdchk(IRR_OFF_RBUF3, 32'h0000_0000);
    wr(8'h20, 32'hffff_ffff);
    rdchk(8'h20, 32'h0000_0000);
    wr(IRR_OFF_RBUF3, 32'hffff_ffff);
    rdchk(IRR_OFF_RBUF3, 32'h0000_0000);
    wr(IRR_OFF_LEADER, 32'hffff_ffff);
    rdchk(IRR_OFF_LEADER, 32'hffff_ffff);
    wr(IRR_OFF_MODE, 32'hffff_ffff);
    rdchk(IRR_OFF_MODE, 32'hc300_ffff);
    wr(IRR_OFF_THR, 32'hffff_ffff);
    rdchk(IRR_OFF_THR, 32'h0000_7f7f);
    // leader frame of 72 cycle-coded bits, first byte lands on top
    run(32'hc000_ff64, 24, 36, 1'b0, PAT_CYC, 72, 8'ha6, 1, 74, 1, 1'b1);
    // leader and edge interrupts gated; short frame proves the buffer cleared at start
    run(32'h0000_ff64, 24, 36, 1'b0, PAT_CYC, 8, 8'h00, 0, 0, 1, 1'b1);
    run(32'hc100_ff64, 24, 36, 1'b1, PAT_PHM, 36, 8'h92, 1, 38, 1, 1'b1);
    // optional leader: short first low is taken as data
    run(32'hc200_ff64, 0, 0, 1'b0, PAT_CYC, 72, 8'ha6, 0, 73, 1, 1'b1);
    // reception off: edges ignored, buffer held
    run(32'hc000_ff64, 24, 36, 1'b0, PAT_PHM, 4, 8'ha6, 0, 0, 0, 1'b0);
    // block disabled: no sample ticks, so nothing is seen
    unit_enable <= 1'b0;
    run(32'hc000_ff64, 24, 36, 1'b0, PAT_PHM, 4, 8'ha6, 0, 0, 0, 1'b1);
    unit_enable <= 1'b1;
    for (int i = 0; i < 4; i++)
      run(32'hc000_ff64, bad_ll[i], bad_lh[i], 1'b0, PAT_CYC, 4, 8'ha6, 0, 6, 0, 1'b1);
    // high-only leader: a short low is not judged, the cycle alone counts
    lim = 32'h140a_0004;
    run(32'hc000_ff64, 3, 57, 1'b0, PAT_CYC, 8, 8'h00, 1, 10, 1, 1'b1);
    // no leader: the first closed cycle is already data
    lim = 32'h000a_0804;
    run(32'hc000_ff64, 0, 0, 1'b0, PAT_CYC, 72, 8'ha6, 0, 73, 1, 1'b1);
    lim = LIM;
    // excess low after a good leader ends reception
    run(32'h8000_28ff, 24, 36, 1'b0, PAT_CYC, 0, 8'h00, 1, 0, 0, 1'b1);
    begin
      int d0;
      d0 = n_done;
      u_irr_ir_source.hold(1'b0, 24);
      u_irr_ir_source.hold(1'b1, 36);
      u_irr_ir_source.hold(1'b0, 80);
      u_irr_ir_source.hold(1'b1, 20);
      cnt(n_done - d0, 1);
    end
    wrap_up();
  end

  initial
  begin
    repeat (40000) @(posedge hclk);
    bad_count++;
    wrap_up();
  end
endmodule : tb_top
